// >>> src/fpm_pkg.sv
// Constants and types for the fieldbus process image map
package fpm_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned BYTE_BITS = 8;
  localparam int unsigned STD_POINTS = 24;
  localparam int unsigned MAX_POINTS = 128;
  localparam int unsigned IN_BYTES = 3;
  localparam int unsigned OUT_BYTES = 4;
  localparam int unsigned STATUS_BYTE = 3;
  localparam int unsigned ST_OUT_FAULT = 0;
  localparam int unsigned ST_IN_FAULT = 1;
  localparam int unsigned ST_GEN_FAULT = 2;
  localparam int unsigned ST_DIAGNOSTIC_FLAG = 3;
  localparam int unsigned ST_RUN = 4;
  localparam int unsigned ST_EXCHANGE = 5;
  localparam int unsigned RATE_SLOW_BPS = 500000;
  localparam int unsigned RATE_FAST_BPS = 2000000;
  localparam int unsigned SLOW_DIV = CLK_HZ / RATE_SLOW_BPS;
  localparam int unsigned FAST_DIV = CLK_HZ / RATE_FAST_BPS;
  localparam int unsigned CFG_CYCLES = 16;
  localparam int unsigned FIFO_DEPTH = 4;
  typedef enum logic [2:0] {
    FPM_ST_RESET = 3'b001,
    FPM_ST_CONFIG = 3'b010,
    FPM_ST_RUN = 3'b100
  } fpm_state_t;
endpackage

// >>> src/fpm_fifo.sv
// Small valid/ready FIFO in flip-flops
`timescale 1ns/1ps
`default_nettype none
module fpm_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  logic ready_r;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  // Next fill count; ready is registered from it so the port comes from a flop
  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end
  // Full and empty from the count
  assign in_ready_o = ready_r;
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rd_r];
  // Pointers and count
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
      ready_r <= 1'b1;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      ready_r <= (cnt_nxt != (AW+1)'(DEPTH));
    end
  end
  // Storage
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_r[wr_r] <= in_data_i;
    end
  end
endmodule
`default_nettype wire

// >>> src/fpm_rate_tick.sv
// Bit-rate tick generator for the selected link rate
`timescale 1ns/1ps
`default_nettype none
module fpm_rate_tick #(
  parameter int unsigned SLOW_DIV = fpm_pkg::SLOW_DIV,
  parameter int unsigned FAST_DIV = fpm_pkg::FAST_DIV
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Control
  input wire logic enable_i,
  input wire logic rate_fast_i,
  // Tick
  output logic tick_o
);
  logic [15:0] cnt_r;
  wire [15:0] limit = rate_fast_i ? 16'(FAST_DIV - 1) : 16'(SLOW_DIV - 1);
  // Divider wraps at the selected limit
  always_ff @(posedge clock_i) begin
    if (reset_i || !enable_i) begin
      cnt_r <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt_r == limit);
      cnt_r <= (cnt_r >= limit) ? '0 : cnt_r + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// >>> src/fpm_map.sv
// Process image map between fieldbus bytes and virtual points
`timescale 1ns/1ps
`default_nettype none
module fpm_map #(
  parameter int unsigned POINTS = fpm_pkg::STD_POINTS,
  parameter int unsigned CFG_CYCLES = fpm_pkg::CFG_CYCLES,
  parameter int unsigned FIFO_DEPTH = fpm_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Static configuration
  input wire logic rate_fast_i,
  // Input bytes from master
  input wire logic in_byte_valid_i,
  output logic in_byte_ready_o,
  input wire logic [1:0] in_byte_index_i,
  input wire logic [7:0] in_byte_data_i,
  // Virtual inputs to base unit
  output logic [POINTS-1:0] virt_in_o,
  output logic virt_in_update_o,
  // Virtual outputs and indicators from base unit
  input wire logic [POINTS-1:0] virt_out_i,
  input wire logic output_fault_flag_i,
  input wire logic input_fault_flag_i,
  input wire logic general_fault_flag_i,
  input wire logic diagnostic_flag_i,
  input wire logic run_flag_i,
  input wire logic exchange_active_i,
  // Output bytes toward master
  input wire logic out_byte_req_i,
  input wire logic [1:0] out_byte_index_i,
  output logic [7:0] out_byte_data_o,
  output logic out_byte_valid_o,
  // Status
  output logic running_o,
  output logic bit_tick_o
);
  localparam int unsigned IW = $clog2(POINTS);
  localparam int unsigned EW = 10;
  fpm_pkg::fpm_state_t state_r, state_nxt;
  logic [15:0] cfg_cnt_r;
  logic [POINTS-1:0] img_in_r;
  logic [7:0] out_r;
  logic out_valid_r;
  logic upd_r;
  logic tick;
  // FIFO signals
  logic f_valid;
  logic f_ready;
  logic [EW-1:0] f_data;
  wire running = (state_r == fpm_pkg::FPM_ST_RUN);
  // Input bytes queue until the map runs
  fpm_fifo #(
    .WIDTH(EW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .in_valid_i(in_byte_valid_i),
    .in_ready_o(in_byte_ready_o),
    .in_data_i({in_byte_index_i, in_byte_data_i}),
    .out_valid_o(f_valid),
    .out_ready_i(f_ready),
    .out_data_o(f_data)
  );
  // Link rate tick
  fpm_rate_tick u_tick (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .enable_i(running),
    .rate_fast_i(rate_fast_i),
    .tick_o(tick)
  );
  // Drain only while running
  assign f_ready = running;
  wire [1:0] f_idx = f_data[9:8];
  wire [7:0] f_byte = f_data[7:0];
  wire f_take = f_valid && f_ready && (32'(f_idx) < fpm_pkg::IN_BYTES);
  // Start-up sequence with no command needed
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      fpm_pkg::FPM_ST_RESET: begin
        state_nxt = fpm_pkg::FPM_ST_CONFIG;
      end
      fpm_pkg::FPM_ST_CONFIG: begin
        if (cfg_cnt_r == 16'(CFG_CYCLES - 1)) begin
          state_nxt = fpm_pkg::FPM_ST_RUN;
        end
      end
      fpm_pkg::FPM_ST_RUN: begin
        state_nxt = fpm_pkg::FPM_ST_RUN;
      end
      default: begin
        state_nxt = fpm_pkg::FPM_ST_RESET;
      end
    endcase
  end
  // State and configuration counter
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_r <= fpm_pkg::FPM_ST_RESET;
      cfg_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (state_r == fpm_pkg::FPM_ST_CONFIG) begin
        cfg_cnt_r <= cfg_cnt_r + 16'h0001;
      end else begin
        cfg_cnt_r <= '0;
      end
    end
  end
  // Next input image: each byte with index below IN_BYTES lands at eight times its index
  logic [POINTS-1:0] img_in_nxt;
  always_comb begin
    img_in_nxt = img_in_r;
    for (int b = 0; b < 8; b++) begin
      if (f_take && (32'(f_idx) * fpm_pkg::BYTE_BITS + b < POINTS)) begin
        img_in_nxt[IW'(32'(f_idx) * fpm_pkg::BYTE_BITS + b)] = f_byte[b];
      end
    end
  end
  // Output byte selection
  logic [7:0] out_sel;
  always_comb begin
    out_sel = 8'h00;
    if (32'(out_byte_index_i) == fpm_pkg::STATUS_BYTE) begin
      out_sel[fpm_pkg::ST_OUT_FAULT] = output_fault_flag_i;
      out_sel[fpm_pkg::ST_IN_FAULT] = input_fault_flag_i;
      out_sel[fpm_pkg::ST_GEN_FAULT] = general_fault_flag_i;
      out_sel[fpm_pkg::ST_DIAGNOSTIC_FLAG] = diagnostic_flag_i;
      out_sel[fpm_pkg::ST_RUN] = run_flag_i;
      out_sel[fpm_pkg::ST_EXCHANGE] = exchange_active_i && running;
      out_sel[7:6] = 2'b00;
    end else begin
      for (int b = 0; b < 8; b++) begin
        if (32'(out_byte_index_i) * fpm_pkg::BYTE_BITS + b < POINTS) begin
          out_sel[b] = virt_out_i[IW'(32'(out_byte_index_i) * fpm_pkg::BYTE_BITS + b)];
        end
      end
    end
  end
  // Registered images and answers
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      img_in_r <= '0;
      out_r <= 8'h00;
      out_valid_r <= 1'b0;
      upd_r <= 1'b0;
    end else begin
      img_in_r <= img_in_nxt;
      upd_r <= f_take;
      out_valid_r <= out_byte_req_i && running;
      if (out_byte_req_i && running) begin
        out_r <= out_sel;
      end
    end
  end
  // Port drive
  assign virt_in_o = img_in_r;
  assign virt_in_update_o = upd_r;
  assign out_byte_data_o = out_r;
  assign out_byte_valid_o = out_valid_r;
  assign running_o = state_r[2];
  assign bit_tick_o = tick;
endmodule
`default_nettype wire

// >>> bench/fpm_map_properties.sv
// Port checks for the process image map
`timescale 1ns/1ps
`default_nettype none
module fpm_map_properties #(
  parameter int unsigned POINTS = 24,
  parameter int unsigned CFG_CYCLES = 16,
  parameter int unsigned FIFO_DEPTH = 4
) (
  // Clock, reset and configuration
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic rate_fast_i,
  // Byte paths
  input wire logic in_byte_valid_i,
  input wire logic in_byte_ready_o,
  input wire logic [1:0] in_byte_index_i,
  input wire logic [7:0] in_byte_data_i,
  input wire logic [POINTS-1:0] virt_in_o,
  input wire logic virt_in_update_o,
  input wire logic [POINTS-1:0] virt_out_i,
  input wire logic output_fault_flag_i,
  input wire logic input_fault_flag_i,
  input wire logic general_fault_flag_i,
  input wire logic diagnostic_flag_i,
  input wire logic run_flag_i,
  input wire logic exchange_active_i,
  input wire logic out_byte_req_i,
  input wire logic [1:0] out_byte_index_i,
  input wire logic [7:0] out_byte_data_o,
  input wire logic out_byte_valid_o,
  // Status
  input wire logic running_o,
  input wire logic bit_tick_o
);
  // One clock domain with synchronous reset
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  logic req_run;
  assign req_run = out_byte_req_i && running_o;
  answer_cause_a: assert property (out_byte_valid_o |-> $past(req_run)) else $error("answer without request");
  answer_due_a: assert property (req_run |=> out_byte_valid_o) else $error("request unanswered");
  status_bits_a: assert property (req_run && out_byte_index_i == 2'h3 |=> out_byte_data_o[4:0] == $past({run_flag_i,
    diagnostic_flag_i, general_fault_flag_i, input_fault_flag_i, output_fault_flag_i})) else $error("status bits");
  exchange_bit_a: assert property (req_run && out_byte_index_i == 2'h3 |=>
    out_byte_data_o[5] == $past(exchange_active_i)) else $error("exchange bit");
  spare_zero_a: assert property (req_run && out_byte_index_i == 2'h3 |=>
    out_byte_data_o[7:6] == 2'h0) else $error("spare bits");
  output_map_a: assert property (req_run && out_byte_index_i != 2'h3 |=>
    out_byte_data_o == $past(virt_out_i[{out_byte_index_i, 3'h0} +: 8])) else $error("output byte");
  auto_start_a: assert property ($fell(reset_i) |-> ##[1:40] running_o) else $error("no start");
  fast_rate_a: assert property (bit_tick_o && rate_fast_i |-> ##62 bit_tick_o) else $error("fast tick");
  slow_rate_a: assert property (bit_tick_o && !rate_fast_i |-> ##250 bit_tick_o) else $error("slow tick");
endmodule
bind fpm_map fpm_map_properties #(.POINTS(POINTS), .CFG_CYCLES(CFG_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) chk_u (.*);
`default_nettype wire

// >>> bench/fpm_master_model.sv
// Master model offering input bytes with valid held until taken
`timescale 1ns/1ps
`default_nettype none
module fpm_master_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Bench control
  input wire logic send_i,
  input wire logic [1:0] index_i,
  input wire logic [7:0] data_i,
  // Byte handshake
  input wire logic ready_i,
  output logic valid_o,
  output logic [1:0] index_o,
  output logic [7:0] data_o
);
  // Idle lines toggle so stale data never passes for fresh
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      valid_o <= 1'b0;
      data_o <= 8'h00;
      index_o <= 2'h0;
    end else if (send_i && !valid_o) begin
      valid_o <= 1'b1;
      index_o <= index_i;
      data_o <= data_i;
    end else if (valid_o && ready_i) begin
      valid_o <= 1'b0;
    end else if (!valid_o) begin
      data_o <= ~data_o;
      index_o <= ~index_o;
    end
  end
endmodule
`default_nettype wire

// >>> bench/fpm_map_tb_top.sv
// Self-checking bench for the process image map
`timescale 1ns/1ps
`default_nettype none
module fpm_map_tb_top;
  typedef struct {logic [1:0] i; logic [7:0] d; logic [23:0] v; logic [5:0] f; logic [7:0] e;} fpm_row_t;
  logic clock_i, reset_i, rate_fast_i, req, send, bval, bready, upd, oval, run, tick;
  logic [1:0] oidx, sidx, bidx;
  logic [7:0] sdat, bdat, odat;
  logic [23:0] vout, vin, img;
  logic [5:0] fl;
  int fail_count, checks_done, n;
  fpm_row_t rows [6] = '{'{2'h0, 8'ha5, 24'h000021, 6'h00, 8'h21}, '{2'h1, 8'h10, 24'h00c300, 6'h00, 8'hc3},
    '{2'h2, 8'h81, 24'h7e0000, 6'h00, 8'h7e}, '{2'h3, 8'h00, 24'hffffff, 6'h3f, 8'h3f},
    '{2'h3, 8'h00, 24'h000000, 6'h15, 8'h15}, '{2'h3, 8'h00, 24'hffffff, 6'h20, 8'h20}};
  fpm_master_model mst_u (.clock_i, .reset_i, .send_i(send), .index_i(sidx), .data_i(sdat), .ready_i(bready),
    .valid_o(bval), .index_o(bidx), .data_o(bdat));
  fpm_map dut_u (.clock_i, .reset_i, .rate_fast_i, .in_byte_valid_i(bval), .in_byte_ready_o(bready),
    .in_byte_index_i(bidx), .in_byte_data_i(bdat), .virt_in_o(vin), .virt_in_update_o(upd), .virt_out_i(vout),
    .output_fault_flag_i(fl[0]), .input_fault_flag_i(fl[1]), .general_fault_flag_i(fl[2]),
    .diagnostic_flag_i(fl[3]), .run_flag_i(fl[4]), .exchange_active_i(fl[5]), .out_byte_req_i(req),
    .out_byte_index_i(oidx), .out_byte_data_o(odat), .out_byte_valid_o(oval), .running_o(run), .bit_tick_o(tick));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [23:0] e, input logic [23:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic tic(input int c);
    repeat (c) @(posedge clock_i);
    #1;
  endtask
  // Bounded wait for a level
  task automatic wt(ref logic s, input logic v);
    n = 0;
    while (s !== v) begin
      tic(1);
      n++;
      if (n > 400) begin
        fail_count++;
        complete_run();
      end
    end
  endtask
  task automatic snd(input logic [1:0] i, input logic [7:0] d);
    sidx = i;
    sdat = d;
    send = 1;
    tic(1);
    send = 0;
  endtask
  task automatic rd(input logic [1:0] i, input logic [7:0] e);
    oidx = i;
    req = 1;
    tic(1);
    req = 0;
    chk({15'h0, 1'b1, e}, {15'h0, oval, odat});
    tic(1);
  endtask
  initial begin
    clock_i = 0;
    forever #4 clock_i = ~clock_i;
  end
  initial begin
    {reset_i, rate_fast_i, req, send, oidx, sidx, sdat, vout, fl, img} = {3'h6, 67'h0};
    fail_count = 0;
    checks_done = 0;
    tic(4);
    reset_i = 0;
    // Fill the queue before start-up until it refuses
    for (int k = 0; k < 5; k++) begin
      snd(2'(k), 8'(8'h11 * (k + 1)));
      if (k < 4) wt(bval, 1'b0);
    end
    tic(2);
    chk(24'h0, {23'h0, bready});
    req = 1;
    tic(1);
    req = 0;
    chk(24'h0, {23'h0, oval});
    wt(run, 1'b1);
    wt(bval, 1'b0);
    tic(8);
    img = 24'h332255;
    chk(img, vin);
    // Table of ordinary transfers
    for (int r = 0; r < 6; r++) begin
      vout = rows[r].v;
      fl = rows[r].f;
      if (rows[r].i != 2'h3) begin
        snd(rows[r].i, rows[r].d);
        wt(upd, 1'b1);
        img[8 * rows[r].i +: 8] = rows[r].d;
        chk(img, vin);
      end
      rd(rows[r].i, rows[r].e);
    end
    // Tick spacing at the fast rate
    wt(tick, 1'b1);
    tic(1);
    wt(tick, 1'b1);
    chk(24'(fpm_pkg::FAST_DIV - 1), 24'(n));
    // Second reset at the slow rate
    reset_i = 1;
    rate_fast_i = 0;
    tic(4);
    chk(24'h0, vin);
    chk(24'h0, {23'h0, run});
    reset_i = 0;
    wt(run, 1'b1);
    wt(tick, 1'b1);
    tic(1);
    wt(tick, 1'b1);
    chk(24'(fpm_pkg::SLOW_DIV - 1), 24'(n));
    rd(2'h3, 8'h20);
    complete_run();
  end
endmodule
`default_nettype wire
